/* File: hw/sdmob_core.sv */
`timescale 1ns/1ps
`default_nettype none
`include "sdmob_defs.svh"
// Operation
// - Mode word is held from one mode load until the next.
// - Bits 0-2 length, 3 order, 4-6 latency, 7-8 mode, 9 write burst.
// - Lengths 1,2,4,8 both orders; full page sequential only.
// - Burst stays inside aligned block of burst length, wrapping.
// - Block from bits above offset; low bits give start offset.
// - Full page starts at column, wraps in row of 4096/2048/1024.
// - Sequential: offsets increment from start modulo burst length.
// - Interleaved: k-th offset is start XOR k.
// - Length one accesses exactly given column, order ignored.
// - Read latency two or three cycles.
// - Drive from edge n+m-1, valid data at edge n+m.
// - Both operating mode bits zero select normal operation.
// - Normal mode applies burst length to reads and writes.
// - Write burst bit one makes writes single column.
// - Mode load: select, row, column, write strobes low, clock enable high.
module sdmob_core
	import sdmob_pkg::*;
(
	input wire logic ref_clk,
	input wire logic resetn,
	input wire sdmob_width_t data_width,
	input wire logic cke,
	input wire logic cs_n,
	input wire logic ras_n,
	input wire logic cas_n,
	input wire logic we_n,
	input wire logic [`SDMOB_MODE_W-1:0] addr,
	output logic [`SDMOB_MODE_W-1:0] mode_word,
	output logic normal_mode,
	output logic mode_illegal,
	output logic col_valid,
	output logic col_is_write,
	output logic [`SDMOB_COL_W-1:0] col_addr,
	output logic rd_drive_en,
	output logic rd_valid,
	output logic [`SDMOB_COL_W-1:0] rd_col,
	output logic busy
);
	// Pins arrive from another domain: two-stage synchronisers
	logic [17:0] pin_s1;
	logic [17:0] pin_s2;
	always_ff @(posedge ref_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			pin_s1 <= 18'h3c000;
			pin_s2 <= 18'h3c000;
		end
		else
		begin
			pin_s1 <= {cs_n, ras_n, cas_n, we_n, cke, addr};
			pin_s2 <= pin_s1;
		end
	end
	logic s_cs_n, s_ras_n, s_cas_n, s_we_n, s_cke;
	logic [`SDMOB_MODE_W-1:0] s_addr;
	assign {s_cs_n, s_ras_n, s_cas_n, s_we_n, s_cke, s_addr} = pin_s2;

	logic cmd_load, cmd_read, cmd_write, cmd_stop;
	assign cmd_load = s_cke & ~s_cs_n & ~s_ras_n & ~s_cas_n & ~s_we_n;
	assign cmd_read = s_cke & ~s_cs_n & s_ras_n & ~s_cas_n & s_we_n;
	assign cmd_write = s_cke & ~s_cs_n & s_ras_n & ~s_cas_n & ~s_we_n;
	assign cmd_stop = s_cke & ~s_cs_n & s_ras_n & s_cas_n & ~s_we_n;

	// Mode register; true hardware powers up unknown, a fixed value is kept
	logic [`SDMOB_MODE_W-1:0] next_mode_word;
	always_comb
	begin
		next_mode_word = mode_word;
		if (cmd_load)
			next_mode_word = {1'b0, s_addr[11:0]};
	end
	always_ff @(posedge ref_clk or negedge resetn)
	begin
		if (!resetn)
			mode_word <= `SDMOB_MODE_RESET;
		else
			mode_word <= next_mode_word;
	end

	// Field decode
	logic [2:0] bl_code;
	logic order_il, wb_single, cl3;
	logic [1:0] op_mode;
	logic [2:0] cl_code;
	assign bl_code = mode_word[`SDMOB_BL_MSB:`SDMOB_BL_LSB];
	assign order_il = mode_word[`SDMOB_ORDER_BIT];
	assign cl_code = mode_word[`SDMOB_CL_MSB:`SDMOB_CL_LSB];
	assign op_mode = mode_word[`SDMOB_OPM_MSB:`SDMOB_OPM_LSB];
	assign wb_single = mode_word[`SDMOB_WB_BIT];
	assign cl3 = (cl_code == 3'h3);
	assign normal_mode = (op_mode == 2'h0);

	function automatic logic bl_legal(input logic [2:0] c, input logic il);
		bl_legal = (c <= 3'h3) || (c == 3'h7 && !il);
	endfunction : bl_legal

	assign mode_illegal = !bl_legal(bl_code, order_il) || !normal_mode ||
		!(cl_code == 3'h2 || cl_code == 3'h3);

	// Offset mask for the aligned block; full page masks by row size
	function automatic logic [`SDMOB_COL_W-1:0] block_mask(
		input logic [2:0] c, input sdmob_width_t w);
		unique case (c)
			3'h1: block_mask = 12'h001;
			3'h2: block_mask = 12'h003;
			3'h3: block_mask = 12'h007;
			3'h7: block_mask = (w == sdmob_w4) ? 12'hfff :
				(w == sdmob_w8) ? 12'h7ff : 12'h3ff;
			default: block_mask = 12'h000;
		endcase
	endfunction : block_mask

	// Column from the address pins per width; bit 10 is the auto-precharge
	// flag, not a column bit, so it never reaches the column counter
	function automatic logic [`SDMOB_COL_W-1:0] col_of(
		input logic [`SDMOB_MODE_W-1:0] a, input sdmob_width_t w);
		unique case (w)
			sdmob_w4: col_of = {a[12:11], a[9:0]};
			sdmob_w8: col_of = {1'b0, a[11], a[9:0]};
			default: col_of = {2'h0, a[9:0]};
		endcase
	endfunction : col_of

	sdmob_state_t state, next_state;
	logic [`SDMOB_COL_W-1:0] base, next_base, start, next_start;
	logic [`SDMOB_COL_W-1:0] mask, next_mask;
	logic [`SDMOB_CNT_W-1:0] k, next_k, len, next_len;
	logic il, next_il;
	logic [`SDMOB_COL_W-1:0] cur_mask, offs;

	assign cur_mask = block_mask(bl_code, data_width);

	always_comb
	begin
		next_state = state;
		next_base = base;
		next_start = start;
		next_mask = mask;
		next_k = k;
		next_len = len;
		next_il = il;
		if (state != sdmob_idle)
		begin
			next_k = k + `SDMOB_CNT_W'(1);
			if (next_k == len || cmd_stop)
				next_state = sdmob_idle;
		end
		if ((cmd_read || cmd_write) && normal_mode)
		begin
			next_state = cmd_read ? sdmob_read : sdmob_write;
			next_k = '0;
			next_il = order_il && bl_code != 3'h7;
			if (cmd_write && wb_single)
				next_mask = 12'h000;
			else
				next_mask = cur_mask;
			next_base = col_of(s_addr, data_width) & ~next_mask;
			next_start = col_of(s_addr, data_width) & next_mask;
			next_len = {1'b0, next_mask} + `SDMOB_CNT_W'(1);
		end
	end
	always_ff @(posedge ref_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			state <= sdmob_idle;
			base <= '0;
			start <= '0;
			mask <= '0;
			k <= '0;
			len <= '0;
			il <= 1'b0;
		end
		else
		begin
			state <= next_state;
			base <= next_base;
			start <= next_start;
			mask <= next_mask;
			k <= next_k;
			len <= next_len;
			il <= next_il;
		end
	end

	logic [`SDMOB_COL_W-1:0] kc;
	assign kc = k[`SDMOB_COL_W-1:0];
	always_comb
	begin
		if (il)
			offs = (start ^ kc) & mask;
		else
			offs = (start + kc) & mask;
	end

	// Column outputs registered so data leaves flip-flops
	logic next_col_valid, next_col_is_write;
	logic [`SDMOB_COL_W-1:0] next_col_addr;
	always_comb
	begin
		next_col_valid = state != sdmob_idle && !cmd_stop;
		next_col_is_write = state == sdmob_write;
		next_col_addr = base | offs;
	end
	always_ff @(posedge ref_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			col_valid <= 1'b0;
			col_is_write <= 1'b0;
			col_addr <= '0;
		end
		else
		begin
			col_valid <= next_col_valid;
			col_is_write <= next_col_is_write;
			col_addr <= next_col_addr;
		end
	end
	assign busy = state != sdmob_idle;

	// Read column enters the pipe on the access cycle, one stage in
	sdmob_latency_pipe u_pipe (
		.ref_clk(ref_clk),
		.resetn(resetn),
		.three_cycles(cl3),
		.in_valid(next_col_valid && !next_col_is_write),
		.in_col(next_col_addr),
		.drive_en(rd_drive_en),
		.out_valid(rd_valid),
		.out_col(rd_col)
	);
endmodule : sdmob_core
`default_nettype wire

/* File: hw/sdmob_defs.svh */
`ifndef SDMOB_DEFS_SVH
`define SDMOB_DEFS_SVH
`define SDMOB_BL_LSB 0
`define SDMOB_BL_MSB 2
`define SDMOB_ORDER_BIT 3
`define SDMOB_CL_LSB 4
`define SDMOB_CL_MSB 6
`define SDMOB_OPM_LSB 7
`define SDMOB_OPM_MSB 8
`define SDMOB_WB_BIT 9
`define SDMOB_MODE_W 13
`define SDMOB_MODE_RESET 13'h0032
`define SDMOB_COL_W 12
`define SDMOB_CNT_W 13
`define SDMOB_DATA_W 16
`endif

/* File: hw/sdmob_latency_pipe.sv */
`timescale 1ns/1ps
`default_nettype none
`include "sdmob_defs.svh"
// Delays column/valid by two or three cycles; three stages shift always
module sdmob_latency_pipe
	import sdmob_pkg::*;
(
	input wire logic ref_clk,
	input wire logic resetn,
	input wire logic three_cycles,
	input wire logic in_valid,
	input wire logic [`SDMOB_COL_W-1:0] in_col,
	output logic drive_en,
	output logic out_valid,
	output logic [`SDMOB_COL_W-1:0] out_col
);
	logic [2:0] vld;
	logic [2:0] next_vld;
	logic [`SDMOB_COL_W-1:0] col [3];
	logic [`SDMOB_COL_W-1:0] next_col [3];
	always_comb
	begin
		next_vld = {vld[1:0], in_valid};
		next_col[0] = in_col;
		next_col[1] = col[0];
		next_col[2] = col[1];
	end
	always_ff @(posedge ref_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			vld <= 3'h0;
			col[0] <= '0;
			col[1] <= '0;
			col[2] <= '0;
		end
		else
		begin
			vld <= next_vld;
			col <= next_col;
		end
	end
	// Output drivers turn on one edge before data is due
	assign drive_en = three_cycles ? vld[1] : vld[0];
	assign out_valid = three_cycles ? vld[2] : vld[1];
	assign out_col = three_cycles ? col[2] : col[1];
endmodule : sdmob_latency_pipe
`default_nettype wire

/* File: hw/sdmob_pkg.sv */
package sdmob_pkg;
	typedef enum logic [2:0]
	{
		sdmob_bl_1 = 3'h0,
		sdmob_bl_2 = 3'h1,
		sdmob_bl_4 = 3'h2,
		sdmob_bl_8 = 3'h3,
		sdmob_bl_page = 3'h7
	} sdmob_bl_t;
	typedef enum logic [1:0]
	{
		sdmob_w4 = 2'h0,
		sdmob_w8 = 2'h1,
		sdmob_w16 = 2'h2
	} sdmob_width_t;
	typedef enum logic [1:0]
	{
		sdmob_idle = 2'h0,
		sdmob_read = 2'h1,
		sdmob_write = 2'h2
	} sdmob_state_t;
endpackage : sdmob_pkg

/* File: testbench/sdmob_core_asserts.sv */
`timescale 1ns/1ps
`default_nettype none
module sdmob_core_asserts
(
	input wire logic ref_clk,
	input wire logic resetn,
	input wire logic cs_n,
	input wire logic ras_n,
	input wire logic cas_n,
	input wire logic we_n,
	input wire logic [12:0] mode_word,
	input wire logic normal_mode,
	input wire logic col_valid,
	input wire logic col_is_write,
	input wire logic [11:0] col_addr,
	input wire logic rd_drive_en,
	input wire logic rd_valid,
	input wire logic [11:0] rd_col
);
	logic [3:0] quiet;
	logic [3:0] next_quiet;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!resetn);
	// Counts from the last load on the pins; sync delay is under five
	always_comb
	begin
		next_quiet = quiet;
		if (!(cs_n | ras_n | cas_n | we_n))
			next_quiet = 4'h0;
		else if (quiet != 4'hf)
			next_quiet = quiet + 4'h1;
	end
	always_ff @(posedge ref_clk or negedge resetn)
		if (!resetn)
			quiet <= 4'h0;
		else
			quiet <= next_quiet;
	sequence rd_beat;
		col_valid && !col_is_write;
	endsequence
	chk_mode_hold: assert property (quiet > 4'h4 |-> $stable(mode_word))
		else $error("mode changed");
	chk_normal_decode: assert property (
		normal_mode == (mode_word[8:7] == 2'h0)) else $error("normal");
	chk_drive_lead: assert property (rd_drive_en |=> rd_valid)
		else $error("drive lead");
	chk_lat_two: assert property (rd_beat ##0 mode_word[6:4] == 3'h2
		|=> rd_valid && rd_col == $past(col_addr)) else $error("lat2");
	chk_lat_three: assert property (rd_beat ##0 mode_word[6:4] == 3'h3
		|-> ##2 rd_valid && rd_col == $past(col_addr, 2)) else $error("lat3");
	chk_seq_step: assert property (
		col_valid && $past(col_valid) && mode_word[3:0] == 4'h2
		|-> col_addr[1:0] == $past(col_addr[1:0]) + 2'h1) else $error("seq");
	chk_block_keep: assert property (
		col_valid && $past(col_valid) && mode_word[2:0] == 3'h3
		|-> col_addr[11:3] == $past(col_addr[11:3])) else $error("block");
	chk_wr_single: assert property (
		col_valid && col_is_write && mode_word[9] |=> !col_valid)
		else $error("write single");
endmodule : sdmob_core_asserts
bind sdmob_core sdmob_core_asserts i_sdmob_core_asserts (.ref_clk, .resetn,
	.cs_n, .ras_n, .cas_n, .we_n, .mode_word, .normal_mode, .col_valid,
	.col_is_write, .col_addr, .rd_drive_en, .rd_valid, .rd_col);
`default_nettype wire

/* File: testbench/sdmob_core_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module sdmob_core_tb
	import sdmob_pkg::*;
;
	logic ref_clk, resetn, cke, cs_n, ras_n, cas_n, we_n;
	logic [12:0] addr, mode_word;
	logic normal_mode, mode_illegal, col_valid, col_is_write;
	logic rd_drive_en, rd_valid, busy;
	logic [11:0] col_addr, rd_col;
	sdmob_width_t data_width;
	int fails = 0;
	int num_checks = 0;
	int cyc = 0;
	sdmob_ctrl_model i_sdmob_ctrl_model (.ref_clk, .cke, .cs_n, .ras_n,
		.cas_n, .we_n, .addr);
	sdmob_core i_sdmob_core (.ref_clk, .resetn, .data_width,
		.cke, .cs_n, .ras_n, .cas_n, .we_n, .addr, .mode_word, .normal_mode,
		.mode_illegal, .col_valid, .col_is_write, .col_addr, .rd_drive_en,
		.rd_valid, .rd_col, .busy);
	initial
	begin
		ref_clk = 1'b0;
		forever #50 ref_clk = ~ref_clk;
	end
	task cmp(input logic [12:0] got, input logic [12:0] exp);
		num_checks++;
		if (got !== exp)
		begin
			fails++;
			$display("wrong value t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : cmp
	task summarize;
		$display("checks=%0d fails=%0d", num_checks, fails);
		if (fails == 0 && num_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : summarize
	task tick;
		@(posedge ref_clk);
		#5;
	endtask : tick
	function logic [11:0] exp_col(input logic [11:0] s, input int n,
		input logic ilv, input int k);
		int o;
		o = ilv ? ((s % n) ^ k) : ((s % n + k) % n);
		return 12'(s - s % n + o);
	endfunction : exp_col
	task run(input logic [12:0] m, input logic [2:0] c, input logic [11:0] s,
		input int n, input int len);
		int k;
		i_sdmob_ctrl_model.load(m);
		cmp(mode_word, m);
		cmp(mode_illegal, 1'b0);
		// Column bits 11:10 ride on address 12:11; bit 10 stays low
		i_sdmob_ctrl_model.issue(c, {s[11:10], 1'b0, s[9:0]});
		for (k = 0; k < 12 && col_valid !== 1'b1; k++)
			tick;
		for (k = 0; k < len; k++)
		begin
			cmp({col_valid, col_addr}, {1'b1, exp_col(s, n, m[3], k)});
			cmp(col_is_write, c == 3'h4);
			tick;
		end
		if (n < 1024)
			cmp(col_valid, 1'b0);
		else
		begin
			i_sdmob_ctrl_model.issue(3'h6, 13'h0000);
			for (k = 0; k < 12 && busy !== 1'b0; k++)
				tick;
			cmp(busy, 1'b0);
		end
	endtask : run
	// Only documented length and latency codes are programmed
	task sc_order;
		run(13'h0022, 3'h5, 12'h005, 4, 4);
		run(13'h003a, 3'h5, 12'h005, 4, 4);
		run(13'h002b, 3'h5, 12'h00d, 8, 8);
		run(13'h0031, 3'h4, 12'h003, 2, 2);
	endtask : sc_order
	task sc_single;
		run(13'h0028, 3'h5, 12'h007, 1, 1);
		run(13'h0222, 3'h4, 12'h006, 4, 1);
		run(13'h0222, 3'h5, 12'h006, 4, 4);
		run(13'h0022, 3'h4, 12'h006, 4, 4);
	endtask : sc_single
	task sc_page;
		run(13'h0037, 3'h5, 12'h3fe, 1024, 4);
		data_width = sdmob_w8;
		run(13'h0037, 3'h5, 12'h7fe, 2048, 4);
		data_width = sdmob_w4;
		run(13'h0037, 3'h5, 12'hffe, 4096, 4);
	endtask : sc_page
	task sc_test_mode;
		int t;
		i_sdmob_ctrl_model.load(13'h00a2);
		cmp(normal_mode, 1'b0);
		cmp(mode_illegal, 1'b1);
		i_sdmob_ctrl_model.issue(3'h5, 13'h0004);
		for (t = 0; t < 8; t++)
		begin
			cmp(col_valid, 1'b0);
			tick;
		end
	endtask : sc_test_mode
	always @(posedge ref_clk)
	begin
		cyc++;
		if (cyc == 3000)
		begin
			fails++;
			summarize;
		end
	end
	initial
	begin
		data_width = sdmob_w16;
		resetn = 1'b0;
		repeat (20) @(posedge ref_clk);
		#1;
		resetn = 1'b1;
		tick;
		cmp(mode_word, 13'h0032);
		sc_order;
		sc_single;
		sc_page;
		sc_test_mode;
		summarize;
	end
endmodule : sdmob_core_tb
`default_nettype wire

/* File: testbench/sdmob_ctrl_model.sv */
`timescale 1ns/1ps
`default_nettype none
module sdmob_ctrl_model
(
	input wire logic ref_clk,
	output logic cke,
	output logic cs_n,
	output logic ras_n,
	output logic cas_n,
	output logic we_n,
	output logic [12:0] addr
);
	parameter int mode_load_delay = 3;
	initial
	begin
		cke = 1'b1;
		{cs_n, ras_n, cas_n, we_n} = 4'hf;
		addr = 13'h0000;
	end
	task issue(input logic [2:0] c, input logic [12:0] a);
		@(posedge ref_clk);
		#1;
		cs_n = 1'b0;
		{ras_n, cas_n, we_n} = c;
		addr = a;
		@(posedge ref_clk);
		#1;
		{cs_n, ras_n, cas_n, we_n} = 4'hf;
		// Stale address is never trusted by the device
		addr = ~a;
	endtask : issue
	// Only called between bursts, so every bank is idle
	task load(input logic [12:0] m);
		issue(3'h0, m & 13'h03ff);
		repeat (mode_load_delay) @(posedge ref_clk);
	endtask : load
endmodule : sdmob_ctrl_model
`default_nettype wire
